// *** tfad_decode.sv ***
// Purpose: device-side decode of host task file and data port accesses
// Assumes: host strobes are much slower than the 10 MHz clock
// Notes:   reads act at strobe start, writes at strobe end
`timescale 1ns/10ps
// Summary of operation
// - LBA high or device write during data request discarded, flagged
// - LBA high read when not busy
// - busy reads other than data port return status instead
// - idle device write stores, reselects
// - device register read when not busy
// - idle command write stores, starts, exits pending
// - busy command write exits pending if reset
// - status read returns status, exits pending
// - both chip selects ignore strobe
// - selected when DEV bit equals number
// - HOB picks current or previous value
// - DMA strobe without request: final or flagged
// - DMA strobe with request moves word
// - chip select during DMA ignores strobe
// - PIO data access moves one word
module tfad_decode (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// host pins, raw
	input  wire logic        cs0_n,
	input  wire logic        cs1_n,
	input  wire logic [2:0]  da,
	input  wire logic        dior_n,
	input  wire logic        diow_n,
	input  wire logic        dmack_n,
	input  wire logic [15:0] dd_in,
	output logic      [15:0] dd_out,
	output logic             dd_oe,
	// device core state
	input  wire logic        bsy,
	input  wire logic        drq,
	input  wire logic        dmarq,
	input  wire logic [7:0]  status_val,
	input  wire logic        hob,
	input  wire logic        lba48_en,
	input  wire logic        dev_num,
	input  wire logic        dev_reset_sup,
	input  wire logic        irq_set,
	// data word exchange with the core
	input  wire logic [15:0] rd_word,
	output logic      [15:0] wr_word,
	output logic             pio_rd_stb,
	output logic             pio_wr_stb,
	output logic             dma_rd_stb,
	output logic             dma_wr_stb,
	output logic             dma_last_stb,
	// command and status to the core
	output logic      [7:0]  cmd_code,
	output logic             cmd_stb,
	output logic      [7:0]  device_reg,
	output logic             dev_sel,
	output logic             int_pending,
	output logic             host_fault_stb
);

	tfad_pkg::tfad_pins_t   raw_pins;
	tfad_pkg::tfad_pins_t   pins;
	logic                   rd_d_r;
	logic                   wr_d_r;
	tfad_pkg::tfad_acc_t    acc_r;
	tfad_pkg::tfad_acc_t    acc_nxt;
	logic [7:0]             lbah_cur_r;
	logic [7:0]             lbah_prev_r;
	logic [7:0]             device_r;
	logic [7:0]             cmd_r;
	logic                   pend_r;
	logic                   burst_r;
	logic [15:0]            dd_out_r;
	logic                   dd_oe_r;
	logic [15:0]            wr_word_r;
	logic [4:0]             stb_r;
	logic                   cmd_stb_r;
	logic                   fault_r;

	assign raw_pins = '{cs0: ~cs0_n, cs1: ~cs1_n, da: da, rd: ~dior_n, wr: ~diow_n,
	                    dmack: ~dmack_n, dd: dd_in};

	tfad_sync #(
		.W       (tfad_pkg::PIN_W),
		.RST_VAL ('0)
	) u_sync (
		.clock (clock),
		.nrst  (nrst),
		.d     (raw_pins),
		.q     (pins)
	);

	// strobe edges
	wire rd_start  = pins.rd & ~rd_d_r;
	wire wr_start  = pins.wr & ~wr_d_r;
	wire wr_end    = ~pins.wr & wr_d_r;
	wire acc_start = rd_start | wr_start;

	// selection and chip select decode
	wire selected  = device_r[tfad_pkg::DEV_BIT_POS] == dev_num;
	wire both_cs   = pins.cs0 & pins.cs1 & ~pins.dmack;
	wire tf_cyc    = pins.cs0 & ~pins.cs1 & ~pins.dmack;
	wire dma_cyc   = pins.dmack & ~pins.cs0 & ~pins.cs1;
	wire a_data    = pins.da == tfad_pkg::ADDR_DATA;
	wire a_lbah    = pins.da == tfad_pkg::ADDR_LBA_HIGH;
	wire a_dev     = pins.da == tfad_pkg::ADDR_DEVICE;
	wire a_cmd     = pins.da == tfad_pkg::ADDR_CMD_STAT;
	wire idle      = ~bsy & ~drq;
	wire dma_go    = dma_cyc & selected & dmarq & (bsy | drq);
	wire dma_end   = dma_cyc & selected & ~dmarq & burst_r;

	// read data selection
	wire [7:0]  lbah_rd  = (lba48_en & hob) ? lbah_prev_r : lbah_cur_r;
	wire [15:0] stat_w   = {8'h00, status_val};

	// access kind from pins at strobe start
	always_comb begin
		acc_nxt = tfad_pkg::ACC_NONE;
		if (both_cs) begin
			acc_nxt = tfad_pkg::ACC_NONE;
		end else if (pins.dmack) begin
			if (dma_go) begin
				acc_nxt = tfad_pkg::ACC_DMA;
			end else if (dma_end) begin
				acc_nxt = tfad_pkg::ACC_DMA_LAST;
			end else if (dma_cyc & selected) begin
				acc_nxt = tfad_pkg::ACC_BAD;
			end
		end else if (tf_cyc & a_dev & pins.wr) begin
			// both devices latch the device register
			if (idle) begin
				acc_nxt = tfad_pkg::ACC_DEVICE;
			end else if (~bsy) begin
				acc_nxt = tfad_pkg::ACC_BAD;
			end
		end else if (tf_cyc & selected) begin
			if (a_cmd & pins.rd) begin
				acc_nxt = tfad_pkg::ACC_STATUS;
			end else if (a_cmd) begin
				acc_nxt = idle ? tfad_pkg::ACC_CMD : tfad_pkg::ACC_CMD_BUSY;
			end else if (pins.rd & bsy & ~a_data) begin
				acc_nxt = tfad_pkg::ACC_STATUS;
			end else if (a_data & ~bsy & drq) begin
				acc_nxt = tfad_pkg::ACC_PIO;
			end else if (a_lbah & pins.rd & ~bsy) begin
				acc_nxt = tfad_pkg::ACC_LBA_HIGH;
			end else if (a_dev & pins.rd & ~bsy) begin
				acc_nxt = tfad_pkg::ACC_DEVICE;
			end else if (a_lbah & pins.wr & ~bsy) begin
				acc_nxt = drq ? tfad_pkg::ACC_BAD : tfad_pkg::ACC_LBA_HIGH;
			end
		end
	end

	// read answer word
	logic [15:0] rd_val;
	logic        rd_ans;
	always_comb begin
		rd_val = 16'h0000;
		rd_ans = 1'b1;
		unique case (acc_nxt)
			tfad_pkg::ACC_STATUS:   rd_val = stat_w;
			tfad_pkg::ACC_LBA_HIGH: rd_val = {8'h00, lbah_rd};
			tfad_pkg::ACC_DEVICE:   rd_val = {8'h00, device_r};
			tfad_pkg::ACC_PIO,
			tfad_pkg::ACC_DMA,
			tfad_pkg::ACC_DMA_LAST: rd_val = rd_word;
			default:                rd_ans = 1'b0;
		endcase
	end

	wire take_rd = rd_start & rd_ans;
	wire wr_do   = wr_end;

	// strobe tracking and access latch
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rd_d_r <= 1'b0;
			wr_d_r <= 1'b0;
			acc_r  <= tfad_pkg::ACC_NONE;
		end else begin
			rd_d_r <= pins.rd;
			wr_d_r <= pins.wr;
			if (acc_start) begin
				acc_r <= acc_nxt;
			end
		end
	end

	// data lines driven only while an answered read stands
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dd_out_r <= 16'h0000;
			dd_oe_r  <= 1'b0;
		end else begin
			if (take_rd) begin
				dd_out_r <= rd_val;
				dd_oe_r  <= 1'b1;
			end else if (~pins.rd) begin
				dd_oe_r  <= 1'b0;
			end
		end
	end

	// write side storage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			lbah_cur_r  <= tfad_pkg::LBA_RST_VAL;
			lbah_prev_r <= tfad_pkg::LBA_RST_VAL;
			device_r    <= tfad_pkg::DEVICE_RST_VAL;
			cmd_r       <= tfad_pkg::CMD_RST_VAL;
			wr_word_r   <= 16'h0000;
		end else if (wr_do) begin
			unique case (acc_r)
				tfad_pkg::ACC_LBA_HIGH: begin
					lbah_prev_r <= lbah_cur_r;
					lbah_cur_r  <= pins.dd[7:0];
				end
				tfad_pkg::ACC_DEVICE:   device_r  <= pins.dd[7:0];
				tfad_pkg::ACC_CMD:      cmd_r     <= pins.dd[7:0];
				tfad_pkg::ACC_PIO,
				tfad_pkg::ACC_DMA,
				tfad_pkg::ACC_DMA_LAST: wr_word_r <= pins.dd;
				default: ;
			endcase
		end
	end

	// one-cycle strobes to the core: pio_rd, pio_wr, dma_rd, dma_wr, dma_last
	wire is_pio   = acc_nxt == tfad_pkg::ACC_PIO;
	wire is_dma   = (acc_nxt == tfad_pkg::ACC_DMA) | (acc_nxt == tfad_pkg::ACC_DMA_LAST);
	wire w_pio    = wr_do & (acc_r == tfad_pkg::ACC_PIO);
	wire w_dma    = wr_do & ((acc_r == tfad_pkg::ACC_DMA) | (acc_r == tfad_pkg::ACC_DMA_LAST));
	wire w_last   = (wr_do & (acc_r == tfad_pkg::ACC_DMA_LAST)) | (rd_start & acc_nxt == tfad_pkg::ACC_DMA_LAST);
	wire cmd_go   = wr_do & (acc_r == tfad_pkg::ACC_CMD);
	wire bad      = (acc_start & acc_nxt == tfad_pkg::ACC_BAD);
	wire pend_clr = cmd_go
	              | (wr_do & acc_r == tfad_pkg::ACC_CMD_BUSY & dev_reset_sup)
	              | (rd_start & tf_cyc & selected & a_cmd);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stb_r     <= 5'h00;
			cmd_stb_r <= 1'b0;
			fault_r   <= 1'b0;
			pend_r    <= 1'b0;
			burst_r   <= 1'b0;
		end else begin
			stb_r     <= {w_last, w_dma, rd_start & is_dma, w_pio, rd_start & is_pio};
			cmd_stb_r <= cmd_go;
			fault_r   <= bad;
			pend_r    <= irq_set | (pend_r & ~pend_clr);
			if (~pins.dmack | (acc_start & acc_nxt == tfad_pkg::ACC_DMA_LAST)) begin
				burst_r <= 1'b0;
			end else if (acc_start & acc_nxt == tfad_pkg::ACC_DMA) begin
				burst_r <= 1'b1;
			end
		end
	end

	assign dd_out         = dd_out_r;
	assign dd_oe          = dd_oe_r;
	assign wr_word        = wr_word_r;
	assign pio_rd_stb     = stb_r[0];
	assign pio_wr_stb     = stb_r[1];
	assign dma_rd_stb     = stb_r[2];
	assign dma_wr_stb     = stb_r[3];
	assign dma_last_stb   = stb_r[4];
	assign cmd_code       = cmd_r;
	assign cmd_stb        = cmd_stb_r;
	assign device_reg     = device_r;
	assign dev_sel        = selected;
	assign int_pending    = pend_r;
	assign host_fault_stb = fault_r;

endmodule : tfad_decode

// *** tfad_decode_bench.sv ***
// Purpose: self-checking bench of the task file decoder
// Assumes: device number 0 until the last check, core levels held by the bench
// Notes:   table rows first, then hand-written cases
`timescale 1ns/10ps
module tfad_decode_bench;
	typedef struct packed {
		logic        b;
		logic        r;
		logic        w;
		logic [2:0]  a;
		logic [15:0] d;
		logic [15:0] x;
	} tfad_row_t;
	localparam logic [2:0] LH = tfad_pkg::ADDR_LBA_HIGH;
	localparam logic [2:0] DV = tfad_pkg::ADDR_DEVICE;
	localparam logic [2:0] CS = tfad_pkg::ADDR_CMD_STAT;
	localparam tfad_row_t rows [8] = '{
		'{1'h0, 1'h0, 1'h1, DV, 16'h00A0, 16'h0000},
		'{1'h0, 1'h0, 1'h0, DV, 16'h0000, 16'h00A0},
		'{1'h0, 1'h0, 1'h1, LH, 16'h0012, 16'h0000},
		'{1'h0, 1'h1, 1'h1, LH, 16'h0034, 16'h0000},
		'{1'h0, 1'h1, 1'h0, LH, 16'h0000, 16'h0012},
		'{1'h1, 1'h0, 1'h0, LH, 16'h0000, 16'h005A},
		'{1'h1, 1'h1, 1'h0, DV, 16'h0000, 16'h005A},
		'{1'h0, 1'h1, 1'h0, tfad_pkg::ADDR_DATA, 16'h0000, 16'hBEEF}};
	logic clock = 1'h0;
	logic nrst = 1'h0;
	logic bsy = 1'h0, drq = 1'h0, dmarq = 1'h0, hob = 1'h0, irq_set = 1'h0, dev_reset_sup = 1'h1;
	logic lba48_en = 1'h1, dev_num = 1'h0;
	logic [7:0]  status_val = 8'h5A;
	logic [15:0] rd_word = 16'hBEEF, q, dd_in, dd_out, wr_word;
	logic [7:0]  cmd_code, device_reg;
	logic cs0_n, cs1_n, dior_n, diow_n, dmack_n, dd_oe, cmd_stb, dev_sel, int_pending;
	logic pio_rd_stb, pio_wr_stb, dma_rd_stb, dma_wr_stb, dma_last_stb, host_fault_stb;
	logic [2:0] da;
	int miscompares = 0, comparisons = 0, nlast = 0, nfault = 0, cycles = 0, nword = 0, ncmd = 0;
	always #50 clock = ~clock;
	tfad_host u_tfad_host (.clock, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dmack_n, .dd_in, .dd_out, .dd_oe);
	tfad_decode u_tfad_decode (.clock, .nrst, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dmack_n, .dd_in,
		.dd_out, .dd_oe, .bsy, .drq, .dmarq, .status_val, .hob, .lba48_en, .dev_num,
		.dev_reset_sup, .irq_set, .rd_word, .wr_word, .pio_rd_stb, .pio_wr_stb, .dma_rd_stb,
		.dma_wr_stb, .dma_last_stb, .cmd_code, .cmd_stb, .device_reg, .dev_sel, .int_pending, .host_fault_stb);
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (dma_last_stb === 1'h1) nlast <= nlast + 1;
		if (host_fault_stb === 1'h1) nfault <= nfault + 1;
		if (cmd_stb === 1'h1) ncmd <= ncmd + 1;
		if ((pio_rd_stb | pio_wr_stb | dma_rd_stb | dma_wr_stb) === 1'h1) nword <= nword + 1;
		if (cycles == 5000) begin
			miscompares++;
			stop_test();
		end
	end
	task cmp16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp16
	task cmp1(input logic got, input logic exp);
		cmp16({15'h0000, got}, {15'h0000, exp});
	endtask : cmp1
	task irq();
		@(posedge clock) irq_set <= 1'h1;
		@(posedge clock) irq_set <= 1'h0;
		@(posedge clock) cmp1(int_pending, 1'h1);
	endtask : irq
	task stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	initial begin
		repeat (8) @(posedge clock);
		cmp1(dd_oe, 1'h0);
		cmp1(int_pending, 1'h0);
		cmp1(dev_sel, 1'h1);
		nrst <= 1'h1;
		foreach (rows[i]) begin
			@(posedge clock);
			bsy <= rows[i].b;
			drq <= rows[i].r;
			u_tfad_host.cyc(1'h0, 1'h1, 1'h1, rows[i].w, rows[i].a, rows[i].d, q);
			if (!rows[i].w) cmp16(q, rows[i].x);
		end
		cmp16(16'(nfault), 16'h0001);
		cmp16(16'(nword), 16'h0001);
		bsy <= 1'h0;
		drq <= 1'h0;
		hob <= 1'h1;
		u_tfad_host.cyc(1'h0, 1'h1, 1'h1, 1'h0, LH, 16'h0000, q);
		cmp16(q, 16'h0000);
		lba48_en <= 1'h0;
		u_tfad_host.cyc(1'h0, 1'h1, 1'h1, 1'h0, LH, 16'h0000, q);
		cmp16(q, 16'h0012);
		hob <= 1'h0;
		irq();
		u_tfad_host.cyc(1'h0, 1'h1, 1'h1, 1'h0, CS, 16'h0000, q);
		cmp16(q, 16'h005A);
		cmp1(int_pending, 1'h0);
		irq();
		u_tfad_host.cyc(1'h0, 1'h1, 1'h1, 1'h1, CS, 16'h00EC, q);
		cmp16({8'h00, cmd_code}, 16'h00EC);
		cmp1(int_pending, 1'h0);
		cmp16(16'(ncmd), 16'h0001);
		irq();
		bsy <= 1'h1;
		u_tfad_host.cyc(1'h0, 1'h1, 1'h1, 1'h1, CS, 16'h0011, q);
		cmp16({8'h00, cmd_code}, 16'h00EC);
		cmp1(int_pending, 1'h0);
		cmp16(16'(ncmd), 16'h0001);
		bsy <= 1'h0;
		u_tfad_host.cyc(1'h0, 1'h0, 1'h1, 1'h1, DV, 16'h00B0, q);
		cmp16({8'h00, device_reg}, 16'h00A0);
		irq();
		u_tfad_host.cyc(1'h0, 1'h0, 1'h1, 1'h0, CS, 16'h0000, q);
		cmp1(int_pending, 1'h1);
		u_tfad_host.cyc(1'h0, 1'h1, 1'h1, 1'h1, DV, 16'h00B0, q);
		cmp1(dev_sel, 1'h0);
		u_tfad_host.cyc(1'h0, 1'h1, 1'h1, 1'h1, DV, 16'h00A0, q);
		cmp1(dev_sel, 1'h1);
		dmarq <= 1'h1;
		drq <= 1'h1;
		u_tfad_host.cyc(1'h0, 1'h1, 1'h1, 1'h1, tfad_pkg::ADDR_DATA, 16'h55AA, q);
		cmp16(wr_word, 16'h55AA);
		u_tfad_host.cyc(1'h1, 1'h1, 1'h0, 1'h0, tfad_pkg::ADDR_DATA, 16'h0000, q);
		cmp16(q, 16'hBEEF);
		u_tfad_host.cyc(1'h1, 1'h1, 1'h0, 1'h1, tfad_pkg::ADDR_DATA, 16'h1234, q);
		cmp16(wr_word, 16'h1234);
		u_tfad_host.cyc(1'h0, 1'h1, 1'h0, 1'h1, tfad_pkg::ADDR_DATA, 16'h5678, q);
		cmp16(wr_word, 16'h1234);
		dmarq <= 1'h0;
		u_tfad_host.cyc(1'h1, 1'h1, 1'h0, 1'h1, tfad_pkg::ADDR_DATA, 16'h9ABC, q);
		cmp16(16'(nlast), 16'h0001);
		cmp16(wr_word, 16'h9ABC);
		u_tfad_host.cyc(1'h1, 1'h1, 1'h0, 1'h0, tfad_pkg::ADDR_DATA, 16'h0000, q);
		cmp16(16'(nfault), 16'h0002);
		cmp16(16'(nword), 16'h0005);
		nrst <= 1'h0;
		@(posedge clock);
		cmp16({device_reg, cmd_code}, 16'h0000);
		cmp16(wr_word, 16'h0000);
		cmp1(int_pending, 1'h0);
		nrst <= 1'h1;
		dev_num <= 1'h1;
		@(posedge clock);
		cmp1(dev_sel, 1'h0);
		stop_test();
	end
endmodule : tfad_decode_bench
bind tfad_decode tfad_decode_properties u_props (.clock, .nrst, .cs0_n, .cs1_n, .da, .dior_n, .dmack_n,
	.dd_out, .dd_oe, .bsy, .status_val, .rd_word, .dev_num, .irq_set, .cmd_stb, .device_reg, .dev_sel,
	.int_pending, .dma_rd_stb, .dma_wr_stb);

// *** tfad_decode_properties.sv ***
// Purpose: port checks of the task file decoder
// Assumes: host keeps the strobe spacing of the hand-over
// Notes:   read answers land 3 clocks after the pin edge
`timescale 1ns/10ps
module tfad_decode_properties (
	// clock and reset
	input wire logic        clock,
	input wire logic        nrst,
	// host pins
	input wire logic        cs0_n,
	input wire logic        cs1_n,
	input wire logic [2:0]  da,
	input wire logic        dior_n,
	input wire logic        dmack_n,
	input wire logic [15:0] dd_out,
	input wire logic        dd_oe,
	// core side
	input wire logic        bsy,
	input wire logic [7:0]  status_val,
	input wire logic [15:0] rd_word,
	input wire logic        dev_num,
	input wire logic        irq_set,
	input wire logic        cmd_stb,
	input wire logic [7:0]  device_reg,
	input wire logic        dev_sel,
	input wire logic        int_pending,
	input wire logic        dma_rd_stb,
	input wire logic        dma_wr_stb
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	chk_oe_read_only: assert property (dd_oe |-> !$past(dior_n, 3))
		else $error("data lines driven outside a read");
	chk_read_needs_sel: assert property ($rose(dd_oe) |-> $past(dev_sel))
		else $error("read answered while not selected");
	chk_cmd_exit_pend: assert property (cmd_stb && !$past(irq_set) |-> !int_pending)
		else $error("command left interrupt pending");
	chk_both_cs_ignored: assert property ((!cs0_n && !cs1_n && dmack_n) [*6] |-> !dd_oe && !cmd_stb)
		else $error("strobe acted with both chip selects");
	chk_dma_cs_ignored: assert property ((!dmack_n && !(cs0_n && cs1_n)) [*6] |-> !dma_rd_stb && !dma_wr_stb)
		else $error("dma strobe acted with a chip select");
	chk_status_clear: assert property ($rose(dd_oe) && $past(da, 3) == tfad_pkg::ADDR_CMD_STAT
		&& !$past(cs0_n, 3) && dmack_n && !$past(irq_set) |-> !int_pending)
		else $error("status read kept interrupt pending");
	chk_busy_status: assert property ($rose(dd_oe) && $past(bsy) && $past(da, 3) != tfad_pkg::ADDR_DATA
		|-> dd_out == {8'h00, $past(status_val)})
		else $error("busy read did not return status");
	chk_data_word: assert property ($rose(dd_oe) && $past(da, 3) == tfad_pkg::ADDR_DATA |-> dd_out == $past(rd_word))
		else $error("data read did not return the core word");
endmodule : tfad_decode_properties

// *** tfad_host.sv ***
// Purpose: host adapter model driving the register bus
// Assumes: one strobe at a time, bench picks the cycle kind
// Notes:   released lines show the inverse of their last level
`timescale 1ns/10ps
module tfad_host (
	// clock
	input wire logic        clock,
	// pins toward the device
	output logic            cs0_n,
	output logic            cs1_n,
	output logic [2:0]      da,
	output logic            dior_n,
	output logic            diow_n,
	output logic            dmack_n,
	output logic [15:0]     dd_in,
	input wire logic [15:0] dd_out,
	input wire logic        dd_oe
);
	logic        drive_r = 1'h0;
	logic [15:0] hd_r    = 16'h0000;
	logic [15:0] last_r  = 16'h0000;
	assign dd_in = (dd_oe === 1'h1) ? dd_out : (drive_r ? hd_r : ~last_r);
	always @(posedge clock) last_r <= dd_in;
	initial begin
		cs0_n = 1'h1;
		cs1_n = 1'h1;
		da = 3'h0;
		dior_n = 1'h1;
		diow_n = 1'h1;
		dmack_n = 1'h1;
	end
	task cyc(input logic c0, input logic c1, input logic dk, input logic w, input logic [2:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge clock);
		cs0_n <= c0;
		cs1_n <= c1;
		dmack_n <= dk;
		da <= a;
		drive_r <= w;
		hd_r <= d;
		@(posedge clock);
		if (w) diow_n <= 1'h0;
		else dior_n <= 1'h0;
		repeat (5) @(posedge clock);
		q = dd_in;
		dior_n <= 1'h1;
		diow_n <= 1'h1;
		repeat (5) @(posedge clock);
		drive_r <= 1'h0;
		cs0_n <= 1'h1;
		cs1_n <= 1'h1;
	endtask : cyc
endmodule : tfad_host

// *** tfad_pkg.sv ***
// Purpose: shared constants and types of the task file access decoder
// Assumes: register addresses are the DA2:0 codes of the command block
// Notes:   pin levels are carried active high once synchronised
package tfad_pkg;

	localparam logic [2:0] ADDR_DATA      = 3'h0;
	localparam logic [2:0] ADDR_LBA_HIGH  = 3'h5;
	localparam logic [2:0] ADDR_DEVICE    = 3'h6;
	localparam logic [2:0] ADDR_CMD_STAT  = 3'h7;

	localparam int         DEV_BIT_POS    = 4;
	localparam logic [7:0] DEVICE_RST_VAL = 8'h00;
	localparam logic [7:0] LBA_RST_VAL    = 8'h00;
	localparam logic [7:0] CMD_RST_VAL    = 8'h00;

	localparam int         SYNC_STAGES    = 2;
	localparam int         PIN_W          = 24;

	// host pins after synchronisation, all active high
	typedef struct packed {
		logic        cs0;
		logic        cs1;
		logic [2:0]  da;
		logic        rd;
		logic        wr;
		logic        dmack;
		logic [15:0] dd;
	} tfad_pins_t;

	// access kind latched at the leading edge of a strobe
	typedef enum logic [3:0] {
		ACC_NONE,
		ACC_PIO,
		ACC_DMA,
		ACC_DMA_LAST,
		ACC_LBA_HIGH,
		ACC_DEVICE,
		ACC_CMD,
		ACC_CMD_BUSY,
		ACC_STATUS,
		ACC_BAD
	} tfad_acc_t;

endpackage : tfad_pkg

// *** tfad_sync.sv ***
// Purpose: two flip-flop synchroniser for a bundle of pin levels
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module tfad_sync #(
	parameter int                W        = 1,
	parameter logic [W-1:0]      RST_VAL  = '0
) (
	// clock and reset
	input  wire logic            clock,
	input  wire logic            nrst,
	// levels
	input  wire logic [W-1:0]    d,
	output logic      [W-1:0]    q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : tfad_sync
